// ===== dds_device.sv
// Synthesizer configuration, mode control and single-tone core.
// Assumes programming pins may change at any time; all are synchronised.
// How it works
// - Five-bit field sets reference multiplication factor.
// - Bypass bit in 1E skips the multiplier.
// - Select pin high uses differential reference pair.
// - Port-select pin high means parallel programming.
// - Bit-order bit high shifts serial words LSB-first.
// - Readback bit high moves read data to output pin.
// - Mode comes from three-bit field at 1F.
// - Mode codes: tone, FSK, ramped FSK, chirp, BPSK.
// - Reset or written code 000 gives single tone.
// - Single tone accumulates first tuning word, reset zero.
// - After reset: zero frequency, phase and amplitude.
// - Host computes tuning word from frequency, clock.
// - Frequency changes keep accumulator phase continuous.
// - Quadrature path fixed 90 degrees; offset shared.
// - Shift and sweep functions gated by mode; amplitude keying and control work in every mode.
// - Single tone offers 12-bit amplitude control choices.
// - Host may update registers on the fly.
// - System clock from multiplier, or reference when bypassed.
// - Host sets range bit by clock rate.
`timescale 1ns/1ps
`default_nettype none
module dds_device #(
  parameter int FTW_W = 48,
  parameter int PH_W  = 14,
  parameter int AMP_W = 12
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Programming pins
  dds_prog_if.device            prog,
  // Board straps and reference pins
  input  wire logic             differential_clock_select,
  input  wire logic             reference_clock_true,
  input  wire logic             reference_clock_complement,
  // Modulation pins
  input  wire logic             modulationPin,
  input  wire logic             keyingPin,
  // Synthesis outputs
  output logic [PH_W-1:0]       phaseI,
  output logic [PH_W-1:0]       phaseQ,
  output logic [AMP_W-1:0]      amplitude,
  // Clock configuration
  output logic [4:0]            clockMultiplier,
  output logic                  pllRange,
  output logic                  system_clock_ref,
  // Mode status
  output dds_pkg::dds_mode_e    mode,
  output logic                  sweepEnable
);
  import dds_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic dds_mode_e decodeMode(input logic [2:0] code);
    case (code)
      3'b001:  decodeMode = MODE_FSK;
      3'b010:  decodeMode = MODE_RFSK;
      3'b011:  decodeMode = MODE_CHIRP;
      3'b100:  decodeMode = MODE_BPSK;
      default: decodeMode = MODE_SINGLE;
    endcase
  endfunction

  function automatic logic [4:0] clampMult(input logic [4:0] v);
    if (v < MULT_MIN) begin
      clampMult = MULT_MIN;
    end else if (v > MULT_MAX) begin
      clampMult = MULT_MAX;
    end else begin
      clampMult = v;
    end
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  localparam int SYNC_W = 25;
  logic [SYNC_W-1:0] pinSync1_reg;
  logic [SYNC_W-1:0] pinSync2_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync1_reg <= '0;
      pinSync2_reg <= '0;
    end else begin
      pinSync1_reg <= {prog.pAddr, prog.pDataWire, prog.portSel, prog.pWr, prog.pRd,
                       prog.sClk, prog.sCsN, prog.sdioWire, differential_clock_select,
                       reference_clock_true, reference_clock_complement, modulationPin,
                       keyingPin};
      pinSync2_reg <= pinSync1_reg;
    end
  end

  logic [5:0] pAddrS;
  logic [7:0] pDataS;
  logic       portSelS;
  logic       pWrS;
  logic       pRdS;
  logic       sClkS;
  logic       sCsNS;
  logic       sdioS;
  logic       diffSelS;
  logic       refTrueS;
  logic       refCompS;
  logic       modS;
  logic       keyS;
  assign {pAddrS, pDataS, portSelS, pWrS, pRdS, sClkS, sCsNS, sdioS, diffSelS,
          refTrueS, refCompS, modS, keyS} = pinSync2_reg;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] regFile [0:REG_COUNT-1];
  logic       wrEn;
  logic [5:0] wrAddr;
  logic [7:0] wrData;

  function automatic logic [7:0] regRead(input logic [5:0] a);
    regRead = (int'(a) < REG_COUNT) ? regFile[a] : 8'h00;
  endfunction

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regFile[i] <= REG_RESET;
      end
    end else if (wrEn && int'(wrAddr) < REG_COUNT) begin
      regFile[wrAddr] <= wrData;
    end
  end

  logic [2:0] modeCode;
  logic       lsbFirst;
  logic       sdoActive;
  assign modeCode  = regFile[ADDR_MODE][2:0];
  assign lsbFirst  = regFile[ADDR_SER_OPT][BIT_LSB_FIRST];
  assign sdoActive = regFile[ADDR_SER_OPT][BIT_SEPARATE_READBACK_PIN];

  // ************************************************************
  // Parallel port
  // ************************************************************
  logic pWrPrev_reg;
  logic parWr;
  assign parWr = portSelS && pWrS && !pWrPrev_reg;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pWrPrev_reg   <= 1'b0;
      prog.pDataD   <= 8'h00;
      prog.pDataDOe <= 1'b0;
    end else begin
      pWrPrev_reg   <= pWrS;
      prog.pDataD   <= regRead(pAddrS);
      prog.pDataDOe <= portSelS && pRdS && !pWrS;
    end
  end

  // ************************************************************
  // Serial port
  // ************************************************************
  logic       sClkPrev_reg;
  logic [4:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] instr_reg;
  logic [7:0] shiftNext;
  logic [2:0] outIdx;
  logic       serActive;
  logic       serRise;
  logic       serFall;
  logic       serReadPhase;
  logic       outBit;
  logic [7:0] readByte;

  assign serActive = !portSelS && !sCsNS;
  assign serRise   = serActive && sClkS && !sClkPrev_reg && bitCnt_reg < 5'h10;
  assign serFall   = serActive && !sClkS && sClkPrev_reg;
  assign shiftNext = lsbFirst ? {sdioS, shift_reg[7:1]} : {shift_reg[6:0], sdioS};
  assign outIdx    = lsbFirst ? bitCnt_reg[2:0] : 3'h7 - bitCnt_reg[2:0];
  assign readByte  = regRead(instr_reg[5:0]);
  assign outBit    = readByte[outIdx];
  assign serReadPhase = instr_reg[BIT_SER_READ] && bitCnt_reg >= 5'h08 && bitCnt_reg < 5'h10;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sClkPrev_reg <= 1'b0;
      bitCnt_reg   <= 5'h00;
      shift_reg    <= 8'h00;
      instr_reg    <= 8'h00;
    end else begin
      sClkPrev_reg <= sClkS;
      if (!serActive) begin
        bitCnt_reg <= 5'h00;
        instr_reg  <= 8'h00;
      end else if (serRise) begin
        shift_reg  <= shiftNext;
        bitCnt_reg <= bitCnt_reg + 5'h01;
        if (bitCnt_reg == 5'h07) begin
          instr_reg <= shiftNext;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog.sdioD   <= 1'b0;
      prog.sdioDOe <= 1'b0;
      prog.sdoD    <= 1'b0;
      prog.sdoDOe  <= 1'b0;
    end else if (!serActive) begin
      prog.sdioDOe <= 1'b0;
      prog.sdoDOe  <= 1'b0;
    end else if (serFall && serReadPhase) begin
      prog.sdioD   <= outBit;
      prog.sdoD    <= outBit;
      prog.sdioDOe <= !sdoActive;
      prog.sdoDOe  <= sdoActive;
    end
  end

  always_comb begin
    wrEn   = parWr;
    wrAddr = pAddrS;
    wrData = pDataS;
    if (serRise && bitCnt_reg == 5'h0F && !instr_reg[BIT_SER_READ]) begin
      wrEn   = 1'b1;
      wrAddr = instr_reg[5:0];
      wrData = shiftNext;
    end
  end

  // ************************************************************
  // Synthesis core
  // ************************************************************
  dds_mode_e        modeNow;
  logic [FTW_W-1:0] ftw1;
  logic [FTW_W-1:0] ftw2;
  logic [FTW_W-1:0] ftwActive;
  logic [FTW_W-1:0] acc_reg;
  logic [PH_W-1:0]  phase1;
  logic [PH_W-1:0]  phase2;
  logic [PH_W-1:0]  phaseSum;
  logic [AMP_W-1:0] keyAmp_reg;
  logic [AMP_W-1:0] progAmp;
  logic [AMP_W-1:0] ampNext;
  logic [7:0]       optReg;
  localparam logic [PH_W-1:0] QUARTER = PH_W'(1 << (PH_W - 2));

  assign modeNow = decodeMode(modeCode);
  assign optReg  = regFile[ADDR_SER_OPT];
  always_comb begin
    ftw1 = '0;
    ftw2 = '0;
    for (int b = 0; b < FTW_W / 8; b++) begin
      ftw1[FTW_W-1-8*b -: 8] = regFile[int'(ADDR_FTW1) + b];
      ftw2[FTW_W-1-8*b -: 8] = regFile[int'(ADDR_FTW2) + b];
    end
  end
  assign phase1  = {regFile[ADDR_PHASE1][PH_W-9:0], regFile[ADDR_PHASE1 + 6'h01]};
  assign phase2  = {regFile[ADDR_PHASE2][PH_W-9:0], regFile[ADDR_PHASE2 + 6'h01]};
  assign progAmp = {regFile[ADDR_AMPLITUDE][AMP_W-9:0], regFile[ADDR_AMPLITUDE + 6'h01]};

  // Second word only in the two plain/ramped shift modes
  assign ftwActive = ((modeNow == MODE_FSK || modeNow == MODE_RFSK) && modS)
                     ? ftw2 : ftw1;
  // Second offset only in phase shift keying
  assign phaseSum = acc_reg[FTW_W-1 -: PH_W]
                    + ((modeNow == MODE_BPSK && modS) ? phase2 : phase1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_reg + ftwActive;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      keyAmp_reg <= '0;
    end else if (keyS && keyAmp_reg != '1) begin
      keyAmp_reg <= keyAmp_reg + 1'b1;
    end else if (!keyS && keyAmp_reg != '0) begin
      keyAmp_reg <= keyAmp_reg - 1'b1;
    end
  end

  always_comb begin
    if (optReg[BIT_KEY_EN]) begin
      ampNext = keyAmp_reg;
    end else if (optReg[BIT_AMP_PROG]) begin
      ampNext = progAmp;
    end else begin
      ampNext = '1;
    end
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseI           <= '0;
      phaseQ           <= QUARTER;
      amplitude        <= '0;
      clockMultiplier  <= MULT_MIN;
      pllRange         <= 1'b0;
      system_clock_ref <= 1'b0;
      mode             <= MODE_SINGLE;
      sweepEnable      <= 1'b0;
    end else begin
      phaseI    <= phaseSum;
      phaseQ    <= phaseSum + QUARTER;
      amplitude <= (acc_reg == '0 && ftwActive == '0) ? '0 : ampNext;
      // Multiplier ratio of one means the reference drives the system clock
      clockMultiplier <= regFile[ADDR_CLK_MULT][BIT_BYPASS] ? 5'h01
                         : clampMult(regFile[ADDR_CLK_MULT][4:0]);
      pllRange  <= regFile[ADDR_CLK_MULT][BIT_PLL_RANGE];
      system_clock_ref <= diffSelS ? (refTrueS && !refCompS) : refTrueS;
      mode        <= modeNow;
      sweepEnable <= (modeNow == MODE_RFSK || modeNow == MODE_CHIRP);
    end
  end

endmodule
`default_nettype wire

// ===== dds_pkg.sv
// Shared constants for the synthesizer configuration block and its host.
// Assumes both ends run on one 100 MHz core clock.
package dds_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PAR_STROBE_NS   = 60;
  localparam int SER_HALF_NS     = 50;
  localparam int PAR_STROBE_CYC  = (PAR_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SER_HALF_CYC    = SER_HALF_NS / CLK_PERIOD_NS;

  // ************************************************************
  // Device register map
  // ************************************************************
  localparam logic [5:0] ADDR_PHASE1    = 6'h00;
  localparam logic [5:0] ADDR_PHASE2    = 6'h02;
  localparam logic [5:0] ADDR_FTW1      = 6'h04;
  localparam logic [5:0] ADDR_FTW2      = 6'h0A;
  localparam logic [5:0] ADDR_CLK_MULT  = 6'h1E;
  localparam logic [5:0] ADDR_MODE      = 6'h1F;
  localparam logic [5:0] ADDR_SER_OPT   = 6'h20;
  localparam logic [5:0] ADDR_AMPLITUDE = 6'h21;
  localparam int         REG_COUNT      = 35;
  localparam logic [7:0] REG_RESET      = 8'h00;

  localparam int BIT_BYPASS     = 5;
  localparam int BIT_PLL_RANGE  = 6;
  localparam int BIT_SEPARATE_READBACK_PIN = 0;
  localparam int BIT_LSB_FIRST  = 1;
  localparam int BIT_AMP_PROG   = 2;
  localparam int BIT_KEY_EN     = 3;
  localparam int BIT_SER_READ   = 7;

  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h14;

  typedef enum logic [2:0] {
    MODE_SINGLE = 3'b000,
    MODE_FSK    = 3'b001,
    MODE_RFSK   = 3'b010,
    MODE_CHIRP  = 3'b011,
    MODE_BPSK   = 3'b100
  } dds_mode_e;

  // ************************************************************
  // Host software registers
  // ************************************************************
  localparam logic [2:0] SW_CMD    = 3'h0;
  localparam logic [2:0] SW_WDATA  = 3'h1;
  localparam logic [2:0] SW_STATUS = 3'h2;
  localparam logic [2:0] SW_RDATA  = 3'h3;
  localparam logic [2:0] SW_CFG    = 3'h4;

endpackage

// ===== dds_prog_if.sv
// Programming pins between host and synthesizer.
// Resolves the shared data pins from the two drivers' enables.
`timescale 1ns/1ps
`default_nettype none
interface dds_prog_if;
  logic       portSel;
  logic [5:0] pAddr;
  logic [7:0] pDataH;
  logic       pDataHOe;
  logic [7:0] pDataD;
  logic       pDataDOe;
  logic       pWr;
  logic       pRd;
  logic       sClk;
  logic       sCsN;
  logic       sdioH;
  logic       sdioHOe;
  logic       sdioD;
  logic       sdioDOe;
  logic       sdoD;
  logic       sdoDOe;
  logic [7:0] pDataWire;
  logic       sdioWire;
  logic       sdoWire;

  assign pDataWire = pDataDOe ? pDataD : (pDataHOe ? pDataH : 8'h00);
  assign sdioWire  = sdioDOe ? sdioD : (sdioHOe ? sdioH : 1'b0);
  assign sdoWire   = sdoDOe ? sdoD : 1'b0;

  modport device (input portSel, pAddr, pWr, pRd, sClk, sCsN, pDataWire, sdioWire,
                  output pDataD, pDataDOe, sdioD, sdioDOe, sdoD, sdoDOe);
  modport host (output portSel, pAddr, pDataH, pDataHOe, pWr, pRd, sClk, sCsN,
                sdioH, sdioHOe, input pDataWire, sdioWire, sdoWire);
endinterface
`default_nettype wire

// ===== dds_host.sv
// Host controller that programs the synthesizer registers.
// Assumes software drives the plain register port on core_clk.
`timescale 1ns/1ps
`default_nettype none
module dds_host (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Software register port
  input  wire logic [2:0] swAddr,
  input  wire logic [7:0] swWdata,
  input  wire logic       swWr,
  input  wire logic       swRd,
  output logic [7:0]      swRdata,
  // Programming pins
  dds_prog_if.host        prog
);
  import dds_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STROBE = 2'b01,
    ST_GAP    = 2'b10,
    ST_SERIAL = 2'b11
  } dds_hstate_e;

  // ************************************************************
  // Software registers
  // ************************************************************
  dds_hstate_e state_reg;
  logic [7:0]  cmd_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  rdata_reg;
  logic        done_reg;
  logic        parMode_reg;
  logic        lsbFirst_reg;
  logic        sdoActive_reg;
  logic        start;
  logic        finish;

  assign start = swWr && swAddr == SW_CMD && state_reg == ST_IDLE;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg       <= 8'h00;
      wdata_reg     <= 8'h00;
      parMode_reg   <= 1'b0;
      lsbFirst_reg  <= 1'b0;
      sdoActive_reg <= 1'b0;
      done_reg      <= 1'b0;
      swRdata       <= 8'h00;
    end else begin
      if (start) begin
        cmd_reg <= swWdata;
      end
      // Track the device's serial options once our own write has landed
      if (finish && !cmd_reg[BIT_SER_READ] && cmd_reg[5:0] == ADDR_SER_OPT) begin
        lsbFirst_reg  <= wdata_reg[BIT_LSB_FIRST];
        sdoActive_reg <= wdata_reg[BIT_SEPARATE_READBACK_PIN];
      end
      if (swWr && swAddr == SW_WDATA) begin
        wdata_reg <= swWdata;
      end
      if (swWr && swAddr == SW_CFG && state_reg == ST_IDLE) begin
        parMode_reg <= swWdata[0];
      end
      done_reg <= finish || (done_reg && !start);
      if (swRd) begin
        if (swAddr == SW_STATUS) begin
          swRdata <= {6'h00, done_reg, state_reg != ST_IDLE};
        end else if (swAddr == SW_RDATA) begin
          swRdata <= rdata_reg;
        end else if (swAddr == SW_CFG) begin
          swRdata <= {7'h00, parMode_reg};
        end else if (swAddr == SW_WDATA) begin
          swRdata <= wdata_reg;
        end else begin
          swRdata <= 8'h00;
        end
      end
    end
  end

  // ************************************************************
  // Pin sequencer
  // ************************************************************
  logic [7:0] timer_reg;
  logic [4:0] bitIdx_reg;
  logic       isRead;
  logic [7:0] curByte;
  logic [2:0] bitPos;

  assign isRead  = cmd_reg[BIT_SER_READ];
  assign curByte = bitIdx_reg[3] ? wdata_reg : cmd_reg;
  assign bitPos  = lsbFirst_reg ? bitIdx_reg[2:0] : 3'h7 - bitIdx_reg[2:0];
  assign finish  = (state_reg == ST_GAP && timer_reg == 8'h00)
                   || (state_reg == ST_SERIAL && bitIdx_reg == 5'h10 && timer_reg == 8'h00);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_IDLE;
      timer_reg     <= 8'h00;
      bitIdx_reg    <= 5'h00;
      rdata_reg     <= 8'h00;
      prog.portSel  <= 1'b0;
      prog.pAddr    <= 6'h00;
      prog.pDataH   <= 8'h00;
      prog.pDataHOe <= 1'b0;
      prog.pWr      <= 1'b0;
      prog.pRd      <= 1'b0;
      prog.sClk     <= 1'b0;
      prog.sCsN     <= 1'b1;
      prog.sdioH    <= 1'b0;
      prog.sdioHOe  <= 1'b0;
    end else begin
      prog.portSel <= parMode_reg;
      if (timer_reg != 8'h00) begin
        timer_reg <= timer_reg - 8'h01;
      end
      case (state_reg)
        ST_IDLE: begin
          if (start && parMode_reg) begin
            state_reg     <= ST_STROBE;
            timer_reg     <= 8'(PAR_STROBE_CYC - 1);
            prog.pAddr    <= swWdata[5:0];
            prog.pDataH   <= wdata_reg;
            prog.pDataHOe <= !swWdata[BIT_SER_READ];
            prog.pWr      <= !swWdata[BIT_SER_READ];
            prog.pRd      <= swWdata[BIT_SER_READ];
          end else if (start) begin
            state_reg  <= ST_SERIAL;
            bitIdx_reg <= 5'h00;
            timer_reg  <= 8'(SER_HALF_CYC - 1);
            prog.sCsN  <= 1'b0;
            prog.sClk  <= 1'b0;
          end
        end
        ST_STROBE: begin
          if (timer_reg == 8'h00) begin
            if (prog.pRd) begin
              rdata_reg <= prog.pDataWire;
            end
            prog.pWr      <= 1'b0;
            prog.pRd      <= 1'b0;
            state_reg     <= ST_GAP;
            timer_reg     <= 8'(PAR_STROBE_CYC - 1);
          end
        end
        ST_GAP: begin
          if (timer_reg == 8'h00) begin
            prog.pDataHOe <= 1'b0;
            state_reg     <= ST_IDLE;
          end
        end
        default: begin
          if (bitIdx_reg == 5'h10) begin
            prog.sCsN    <= 1'b1;
            prog.sdioHOe <= 1'b0;
            if (timer_reg == 8'h00) begin
              state_reg <= ST_IDLE;
            end
          end else if (!prog.sClk) begin
            prog.sdioH   <= curByte[bitPos];
            prog.sdioHOe <= !(isRead && bitIdx_reg[3]);
            if (timer_reg == 8'h00) begin
              prog.sClk <= 1'b1;
              timer_reg <= 8'(SER_HALF_CYC - 1);
            end
          end else if (timer_reg == 8'h00) begin
            if (isRead && bitIdx_reg[3]) begin
              rdata_reg[bitPos] <= sdoActive_reg ? prog.sdoWire : prog.sdioWire;
            end
            prog.sClk  <= 1'b0;
            bitIdx_reg <= bitIdx_reg + 5'h01;
            timer_reg  <= 8'(SER_HALF_CYC - 1);
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== dds_checker.sv
// Concurrent checks on the programming pins and synthesis outputs.
// Assumes the bench instantiates it beside the interface.
`timescale 1ns/1ps
`default_nettype none
module dds_checker (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               arst_n,
  // Programming pins
  input wire logic               portSel,
  input wire logic               pWr,
  input wire logic               pRd,
  input wire logic               pDataDOe,
  input wire logic               sClk,
  input wire logic               sCsN,
  input wire logic               sdioDOe,
  input wire logic               sdoDOe,
  // Device outputs
  input wire logic [13:0]        phaseI,
  input wire logic [13:0]        phaseQ,
  input wire logic [4:0]         clockMultiplier,
  input wire dds_pkg::dds_mode_e mode,
  input wire logic               sweepEnable
);
  import dds_pkg::*;
  // ****************
  // Sequences
  // ****************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_hold;
    pWr[*6] ##1 !pWr;
  endsequence
  sequence s_rd_answer;
    ##[2:4] pDataDOe;
  endsequence
  // ****************
  // Assertions
  // ****************
  a_quad_phase: assert property (phaseQ == phaseI + 14'h1000)
    else $error("quadrature offset wrong");
  a_mode_decode: assert property (mode <= MODE_BPSK)
    else $error("mode code out of range");
  a_mult_clamp: assert property (clockMultiplier == 5'h01 ||
    (clockMultiplier >= MULT_MIN && clockMultiplier <= MULT_MAX)) else $error("multiplier bad");
  a_sweep_gate: assert property (sweepEnable == (mode == MODE_RFSK || mode == MODE_CHIRP))
    else $error("sweep gating wrong");
  a_wr_strobe: assert property ($rose(pWr) |-> s_wr_hold)
    else $error("write strobe length wrong");
  a_rd_answer: assert property ($rose(pRd) && portSel |-> s_rd_answer)
    else $error("parallel read not answered");
  a_serial_oe: assert property (sdioDOe || sdoDOe |-> !portSel)
    else $error("serial pin driven in parallel mode");
  a_one_readback: assert property (!(sdioDOe && sdoDOe))
    else $error("both readback pins driven");
  a_sclk_idle: assert property (sCsN |-> !sClk)
    else $error("serial clock runs outside frame");
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench: host and device joined by the programming pins.
// Assumes software reaches the host through its plain register port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dds_pkg::*;
  logic core_clk, arst_n, diffSel, refT, refC, swWr, swRd, pllRange, sysRef, sweepEnable;
  logic modPin, keyPin;
  logic [2:0] swAddr;
  logic [7:0] swWdata, swRdata, q;
  logic [13:0] phaseI, phaseQ, p0;
  logic [11:0] amplitude;
  logic [4:0] clockMultiplier;
  dds_mode_e mode;
  int miscompares, n_checks, cyc, k;
  dds_prog_if dds_prog_if_inst();
  dds_device dds_device_inst (.core_clk(core_clk), .arst_n(arst_n), .prog(dds_prog_if_inst),
    .differential_clock_select(diffSel), .reference_clock_true(refT),
    .reference_clock_complement(refC), .modulationPin(modPin), .keyingPin(keyPin),
    .phaseI(phaseI), .phaseQ(phaseQ), .amplitude(amplitude), .clockMultiplier(clockMultiplier),
    .pllRange(pllRange), .system_clock_ref(sysRef), .mode(mode), .sweepEnable(sweepEnable));
  dds_host dds_host_inst (.core_clk(core_clk), .arst_n(arst_n), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .prog(dds_prog_if_inst));
  dds_checker dds_checker_inst (.core_clk(core_clk), .arst_n(arst_n),
    .portSel(dds_prog_if_inst.portSel), .pWr(dds_prog_if_inst.pWr),
    .pRd(dds_prog_if_inst.pRd), .pDataDOe(dds_prog_if_inst.pDataDOe),
    .sClk(dds_prog_if_inst.sClk), .sCsN(dds_prog_if_inst.sCsN),
    .sdioDOe(dds_prog_if_inst.sdioDOe), .sdoDOe(dds_prog_if_inst.sdoDOe), .phaseI(phaseI),
    .phaseQ(phaseQ), .clockMultiplier(clockMultiplier), .mode(mode), .sweepEnable(sweepEnable));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge core_clk);
    swWr <= 1'b0;
  endtask
  task automatic sw_rd(input logic [2:0] a);
    @(posedge core_clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge core_clk);
    swRd <= 1'b0;
    #1 q = swRdata;
  endtask
  task automatic dev(input logic [5:0] a, input logic [7:0] d, input logic rd);
    int i;
    sw_wr(SW_WDATA, d);
    sw_wr(SW_CMD, {rd, 1'b0, a});
    q = 8'h01;
    for (i = 0; i < 400 && q[0] !== 1'b0; i++) sw_rd(SW_STATUS);
    chk(q[1:0], 2'b10);
    sw_rd(SW_RDATA);
  endtask
  task automatic t_clock();
    logic [4:0] v;
    sw_wr(SW_CFG, 8'h01);
    for (k = 0; k < 32; k += 3) begin
      v = k[4:0];
      dev(ADDR_CLK_MULT, {3'h0, v}, 1'b0);
      chk(clockMultiplier, v < MULT_MIN ? MULT_MIN : (v > MULT_MAX ? MULT_MAX : v));
    end
    dev(ADDR_CLK_MULT, 8'h65, 1'b0);
    chk(clockMultiplier, 5'h01);
    chk(pllRange, 1'b1);
    dev(ADDR_CLK_MULT, 8'h00, 1'b1);
    chk(q, 8'h65);
    for (k = 0; k < 4; k++) begin
      @(posedge core_clk);
      {diffSel, refT, refC} <= {k[1:0], k[1]};
      repeat (5) @(posedge core_clk);
      chk(sysRef, k == 1);
    end
  endtask
  task automatic t_mode();
    for (k = 0; k < 8; k++) begin
      dev(ADDR_MODE, k[7:0], 1'b0);
      chk(mode, k > 4 ? 3'b000 : k[2:0]);
      chk(sweepEnable, k == 2 || k == 3);
    end
  endtask
  task automatic t_tone();
    dev(ADDR_FTW1, 8'h01, 1'b0);
    #1 p0 = phaseI;
    @(posedge core_clk);
    #1 chk(14'(phaseI - p0), 14'h0040);
    chk(amplitude, 12'hFFF);
    dev(ADDR_FTW1, 8'h02, 1'b0);
    #1 p0 = phaseI;
    @(posedge core_clk);
    #1 chk(14'(phaseI - p0), 14'h0080);
    dev(6'h30, 8'hAA, 1'b0);
    dev(6'h30, 8'h00, 1'b1);
    chk(q, 8'h00);
  endtask
  task automatic t_pins();
    dev(ADDR_FTW2, 8'h04, 1'b0);
    modPin <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 p0 = phaseI;
    @(posedge core_clk);
    #1 chk(14'(phaseI - p0), 14'h0080);
    dev(ADDR_MODE, 8'h01, 1'b0);
    #1 p0 = phaseI;
    @(posedge core_clk);
    #1 chk(14'(phaseI - p0), 14'h0100);
    dev(ADDR_SER_OPT, 8'h08, 1'b0);
    keyPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1 p0 = 14'(amplitude);
    @(posedge core_clk);
    #1 chk(12'(amplitude - p0[11:0]), 12'h001);
    {modPin, keyPin} <= 2'b00;
  endtask
  task automatic t_serial();
    sw_wr(SW_CFG, 8'h00);
    for (k = 2; k < 4; k++) begin
      dev(ADDR_SER_OPT, k[7:0], 1'b0);
      dev(ADDR_MODE, 8'h03, 1'b0);
      chk(mode, MODE_CHIRP);
      dev(ADDR_MODE, 8'h00, 1'b1);
      chk(q, 8'h03);
    end
    dev(ADDR_SER_OPT, 8'h00, 1'b0);
    dev(ADDR_MODE, 8'h00, 1'b0);
    chk(mode, MODE_SINGLE);
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {arst_n, diffSel, refT, refC, swWr, swRd, swAddr, swWdata, modPin, keyPin} = '0;
    {miscompares, n_checks, cyc} = '0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (12) @(posedge core_clk);
    chk(mode, MODE_SINGLE);
    chk(clockMultiplier, MULT_MIN);
    chk(amplitude, 12'h000);
    chk(phaseI, 14'h0000);
    t_clock();
    t_mode();
    t_tone();
    t_pins();
    t_serial();
    end_sim();
  end
endmodule
`default_nettype wire
